//--- bfs_shift_unit.sv
/*
 * bfs_pkg: shared constants, opcodes and status bit positions.
 * bfs_shift_unit: combinational shift, rotate and nibble-swap unit.
 * Assumes the caller supplies the old carry and writes the flag results
 * back only when flags_we_o is high.
 */
package bfs_pkg;
	localparam int unsigned BFS_DATA_W   = 8;
	localparam int unsigned BFS_PC_W     = 16;
	localparam int unsigned BFS_K_W      = 7;
	localparam int unsigned BFS_NREG     = 32;
	localparam int unsigned BFS_NIO      = 32;
	localparam int unsigned BFS_RADR_W   = 5;
	localparam int unsigned BFS_BIT_W    = 3;
	localparam int unsigned BFS_MSB      = 7;
	localparam int unsigned BFS_LSB      = 0;
	localparam int unsigned BFS_NIB      = 4;

	// status register bit positions
	localparam int unsigned BFS_SB_C     = 0;
	localparam int unsigned BFS_SB_Z     = 1;
	localparam int unsigned BFS_SB_N     = 2;
	localparam int unsigned BFS_SB_V     = 3;
	localparam int unsigned BFS_SB_S     = 4;
	localparam int unsigned BFS_SB_H     = 5;
	localparam int unsigned BFS_SB_T     = 6;
	localparam int unsigned BFS_SB_I     = 7;

	localparam logic [7:0]  BFS_STATUS_REGISTER_RST = 8'h00;
	localparam logic [7:0]  BFS_BYTE_RST = 8'h00;
	localparam logic [7:0]  BFS_BYTE_ZERO = 8'h00;
	localparam logic [15:0] BFS_PC_RST   = 16'h0000;
	localparam logic [15:0] BFS_PC_STEP  = 16'h0001;

	typedef enum logic [5:0] {
		bfs_op_nop,
		bfs_op_branch_overflow_clear,
		bfs_op_branch_irq_enabled,
		bfs_op_branch_irq_disabled,
		bfs_op_io_bit_set,
		bfs_op_io_bit_clear,
		bfs_op_shift_left_logical,
		bfs_op_shift_right_logical,
		bfs_op_rotate_left_carry,
		bfs_op_rotate_right_carry,
		bfs_op_shift_right_arith,
		bfs_op_nibble_swap,
		bfs_op_status_bit_set,
		bfs_op_status_bit_clear,
		bfs_op_store_bit_to_flag,
		bfs_op_load_bit_from_flag,
		bfs_op_carry_flag_set,
		bfs_op_carry_flag_clear,
		bfs_op_negative_flag_set,
		bfs_op_negative_flag_clear,
		bfs_op_zero_flag_set,
		bfs_op_zero_flag_clear,
		bfs_op_global_irq_on,
		bfs_op_global_irq_off,
		bfs_op_sign_flag_set,
		bfs_op_sign_flag_clear,
		bfs_op_overflow_flag_set,
		bfs_op_overflow_flag_clear,
		bfs_op_transfer_flag_set,
		bfs_op_transfer_flag_clear,
		bfs_op_half_carry_set,
		bfs_op_half_carry_clear,
		bfs_op_register_copy
	} bfs_op_t;

	typedef enum logic [1:0] {
		bfs_st_idle,
		bfs_st_branch,
		bfs_st_io
	} bfs_state_t;
endpackage : bfs_pkg

`timescale 1ns/1ns
module bfs_shift_unit
	import bfs_pkg::*;
#(
	parameter int unsigned DATA_W = bfs_pkg::BFS_DATA_W
) (
	// operation
	input  wire bfs_pkg::bfs_op_t     op_i,
	input  wire logic [DATA_W-1:0]    value_i,
	input  wire logic                 carry_i,
	// results
	output logic      [DATA_W-1:0]    result_o,
	output logic                      carry_o,
	output logic                      zero_o,
	output logic                      neg_o,
	output logic                      ovf_o,
	output logic                      flags_we_o
);
	always_comb begin
		result_o   = value_i;
		carry_o    = carry_i;
		flags_we_o = 1'b1;
		unique case (op_i)
			bfs_op_shift_left_logical: begin
				result_o = {value_i[DATA_W-2:0], 1'b0};
				carry_o  = value_i[DATA_W-1];
			end
			bfs_op_shift_right_logical: begin
				result_o = {1'b0, value_i[DATA_W-1:1]};
				carry_o  = value_i[BFS_LSB];
			end
			bfs_op_rotate_left_carry: begin
				result_o = {value_i[DATA_W-2:0], carry_i};
				carry_o  = value_i[DATA_W-1];
			end
			bfs_op_rotate_right_carry: begin
				result_o = {carry_i, value_i[DATA_W-1:1]};
				carry_o  = value_i[BFS_LSB];
			end
			bfs_op_shift_right_arith: begin
				result_o = {value_i[DATA_W-1], value_i[DATA_W-1:1]};
				carry_o  = value_i[BFS_LSB];
			end
			bfs_op_nibble_swap: begin
				result_o   = {value_i[BFS_NIB-1:0], value_i[DATA_W-1:BFS_NIB]};
				flags_we_o = 1'b0;
			end
			default: begin
				flags_we_o = 1'b0;
			end
		endcase
		zero_o = (result_o == '0);
		neg_o  = result_o[DATA_W-1];
		// overflow after a shift is negative xor carry
		ovf_o  = neg_o ^ carry_o;
	end
endmodule : bfs_shift_unit

//--- bfs_datapath.sv
/*
 * bfs_datapath: execution of branches on overflow and interrupt flags,
 * I/O bit set and clear, shifts and rotates, bit transfer, status flag
 * set and clear, and register copy.
 * Assumes a fetch stage presents one decoded instruction with start_i
 * only while busy_o is low, on the same clock.
 */
`timescale 1ns/1ns
module bfs_datapath
	import bfs_pkg::*;
#(
	parameter int unsigned DATA_W = bfs_pkg::BFS_DATA_W,
	parameter int unsigned PC_W   = bfs_pkg::BFS_PC_W,
	parameter int unsigned K_W    = bfs_pkg::BFS_K_W,
	parameter int unsigned NREG   = bfs_pkg::BFS_NREG,
	parameter int unsigned NIO    = bfs_pkg::BFS_NIO
) (
	// clock and reset
	input  wire logic                              mclk_i,
	input  wire logic                              rst_b_i,
	// decoded instruction
	input  wire logic                              start_i,
	input  wire bfs_pkg::bfs_op_t                  op_i,
	input  wire logic [bfs_pkg::BFS_RADR_W-1:0]    rd_sel_i,
	input  wire logic [bfs_pkg::BFS_RADR_W-1:0]    rr_sel_i,
	input  wire logic [bfs_pkg::BFS_RADR_W-1:0]    io_sel_i,
	input  wire logic [bfs_pkg::BFS_BIT_W-1:0]     bit_sel_i,
	input  wire logic [K_W-1:0]                    k_i,
	// observation read ports
	input  wire logic [bfs_pkg::BFS_RADR_W-1:0]    gpr_rd_addr_i,
	input  wire logic [bfs_pkg::BFS_RADR_W-1:0]    io_rd_addr_i,
	// state outputs
	output logic      [PC_W-1:0]                   pc_o,
	output logic      [DATA_W-1:0]                 status_register_o,
	output logic      [DATA_W-1:0]                 gpr_rd_data_o,
	output logic      [DATA_W-1:0]                 io_rd_data_o,
	output logic                                   busy_o,
	output logic                                   done_o
);
	typedef struct packed {
		bfs_state_t                          fsm;
		logic [PC_W-1:0]                     pc;
		logic [PC_W-1:0]                     target;
		logic [DATA_W-1:0]                   status_register;
		logic [NREG-1:0][DATA_W-1:0]         gpr;
		logic [NIO-1:0][DATA_W-1:0]          io;
		logic                                io_set;
		logic [BFS_RADR_W-1:0]               io_adr;
		logic [BFS_BIT_W-1:0]                io_bit;
		logic [DATA_W-1:0]                   gpr_q;
		logic [DATA_W-1:0]                   io_q;
		logic                                busy;
		logic                                done;
	} bfs_regs_t;

	bfs_regs_t         r;
	bfs_regs_t         next_r;

	logic [DATA_W-1:0] rd_val;
	logic [DATA_W-1:0] rr_val;
	logic [DATA_W-1:0] sh_result;
	logic              sh_carry;
	logic              sh_zero;
	logic              sh_neg;
	logic              sh_ovf;
	logic              sh_we;
	logic [PC_W-1:0]   pc_step;
	logic [PC_W-1:0]   pc_branch;
	logic              br_taken;

	assign rd_val    = r.gpr[rd_sel_i];
	assign rr_val    = r.gpr[rr_sel_i];
	assign pc_step   = PC_W'(r.pc + BFS_PC_STEP);
	// sign-extended offset plus one
	assign pc_branch = PC_W'(r.pc + {{(PC_W-K_W){k_i[K_W-1]}}, k_i} + BFS_PC_STEP);

	bfs_shift_unit #(
		.DATA_W     (DATA_W)
	) u_shift (
		.op_i       (op_i),
		.value_i    (rd_val),
		.carry_i    (r.status_register[BFS_SB_C]),
		.result_o   (sh_result),
		.carry_o    (sh_carry),
		.zero_o     (sh_zero),
		.neg_o      (sh_neg),
		.ovf_o      (sh_ovf),
		.flags_we_o (sh_we)
	);

	always_comb begin
		br_taken = 1'b0;
		unique case (op_i)
			bfs_op_branch_overflow_clear: br_taken = ~r.status_register[BFS_SB_V];
			bfs_op_branch_irq_enabled:    br_taken = r.status_register[BFS_SB_I];
			bfs_op_branch_irq_disabled:   br_taken = ~r.status_register[BFS_SB_I];
			default:                      br_taken = 1'b0;
		endcase
	end

	always_comb begin
		next_r       = r;
		next_r.done  = 1'b0;
		next_r.gpr_q = r.gpr[gpr_rd_addr_i];
		next_r.io_q  = r.io[io_rd_addr_i];
		unique case (r.fsm)
			bfs_st_idle: begin
				if (start_i) begin
					next_r.pc   = pc_step;
					next_r.done = 1'b1;
					unique case (op_i)
						bfs_op_branch_overflow_clear,
						bfs_op_branch_irq_enabled,
						bfs_op_branch_irq_disabled: begin
							// taken branch spends a second cycle, no flags touched
							if (br_taken) begin
								next_r.target = pc_branch;
								next_r.fsm    = bfs_st_branch;
								next_r.busy   = 1'b1;
								next_r.done   = 1'b0;
							end
						end
						bfs_op_io_bit_set,
						bfs_op_io_bit_clear: begin
							next_r.io_set = (op_i == bfs_op_io_bit_set);
							next_r.io_adr = io_sel_i;
							next_r.io_bit = bit_sel_i;
							next_r.fsm    = bfs_st_io;
							next_r.busy   = 1'b1;
							next_r.done   = 1'b0;
						end
						bfs_op_shift_left_logical,
						bfs_op_shift_right_logical,
						bfs_op_rotate_left_carry,
						bfs_op_rotate_right_carry,
						bfs_op_shift_right_arith,
						bfs_op_nibble_swap: begin
							next_r.gpr[rd_sel_i] = sh_result;
							if (sh_we) begin
								next_r.status_register[BFS_SB_C] = sh_carry;
								next_r.status_register[BFS_SB_Z] = sh_zero;
								next_r.status_register[BFS_SB_N] = sh_neg;
								next_r.status_register[BFS_SB_V] = sh_ovf;
							end
						end
						bfs_op_status_bit_set: begin
							next_r.status_register[bit_sel_i] = 1'b1;
						end
						bfs_op_status_bit_clear: begin
							next_r.status_register[bit_sel_i] = 1'b0;
						end
						bfs_op_store_bit_to_flag: begin
							next_r.status_register[BFS_SB_T] = rr_val[bit_sel_i];
						end
						bfs_op_load_bit_from_flag: begin
							next_r.gpr[rd_sel_i][bit_sel_i] = r.status_register[BFS_SB_T];
						end
						bfs_op_carry_flag_set:      next_r.status_register[BFS_SB_C] = 1'b1;
						bfs_op_carry_flag_clear:    next_r.status_register[BFS_SB_C] = 1'b0;
						bfs_op_negative_flag_set:   next_r.status_register[BFS_SB_N] = 1'b1;
						bfs_op_negative_flag_clear: next_r.status_register[BFS_SB_N] = 1'b0;
						bfs_op_zero_flag_set:       next_r.status_register[BFS_SB_Z] = 1'b1;
						bfs_op_zero_flag_clear:     next_r.status_register[BFS_SB_Z] = 1'b0;
						bfs_op_global_irq_on:       next_r.status_register[BFS_SB_I] = 1'b1;
						bfs_op_global_irq_off:      next_r.status_register[BFS_SB_I] = 1'b0;
						bfs_op_sign_flag_set:       next_r.status_register[BFS_SB_S] = 1'b1;
						bfs_op_sign_flag_clear:     next_r.status_register[BFS_SB_S] = 1'b0;
						bfs_op_overflow_flag_set:   next_r.status_register[BFS_SB_V] = 1'b1;
						bfs_op_overflow_flag_clear: next_r.status_register[BFS_SB_V] = 1'b0;
						bfs_op_transfer_flag_set:   next_r.status_register[BFS_SB_T] = 1'b1;
						bfs_op_transfer_flag_clear: next_r.status_register[BFS_SB_T] = 1'b0;
						bfs_op_half_carry_set:      next_r.status_register[BFS_SB_H] = 1'b1;
						bfs_op_half_carry_clear:    next_r.status_register[BFS_SB_H] = 1'b0;
						bfs_op_register_copy: begin
							next_r.gpr[rd_sel_i] = rr_val;
						end
						default: begin
							// nop or unused code: only the PC advances
						end
					endcase
				end
			end
			bfs_st_branch: begin
				// second cycle of a taken branch loads the target
				next_r.pc   = r.target;
				next_r.fsm  = bfs_st_idle;
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
			bfs_st_io: begin
				// read-modify-write of one bit, other bits kept
				next_r.io[r.io_adr][r.io_bit] = r.io_set;
				next_r.fsm  = bfs_st_idle;
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
			default: begin
				next_r.fsm  = bfs_st_idle;
				next_r.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			r.fsm    <= bfs_st_idle;
			r.pc     <= BFS_PC_RST;
			r.target <= BFS_PC_RST;
			r.status_register   <= BFS_STATUS_REGISTER_RST;
			r.gpr    <= '0;
			r.io     <= '0;
			r.io_set <= 1'b0;
			r.io_adr <= '0;
			r.io_bit <= '0;
			r.gpr_q  <= BFS_BYTE_RST;
			r.io_q   <= BFS_BYTE_RST;
			r.busy   <= 1'b0;
			r.done   <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign pc_o              = r.pc;
	assign status_register_o = r.status_register;
	assign gpr_rd_data_o     = r.gpr_q;
	assign io_rd_data_o      = r.io_q;
	assign busy_o            = r.busy;
	assign done_o            = r.done;
endmodule : bfs_datapath

//--- bfs_datapath_chk.sv
/*
 * bfs_datapath_chk: timing and flag assertions on the datapath ports.
 * Assumes one clock, synchronous active-low reset; bound to bfs_datapath.
 */
`timescale 1ns/1ns
module bfs_datapath_chk
	import bfs_pkg::*;
(
	// clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          rst_b_i,
	// instruction
	input  wire logic                          start_i,
	input  wire bfs_pkg::bfs_op_t              op_i,
	input  wire logic [bfs_pkg::BFS_BIT_W-1:0] bit_sel_i,
	input  wire logic [bfs_pkg::BFS_K_W-1:0]   k_i,
	// state
	input  wire logic [15:0]                   pc_o,
	input  wire logic [7:0]                    status_register_o,
	input  wire logic                          busy_o,
	input  wire logic                          done_o
);
	logic        go;
	logic [15:0] k_ext;
	assign go = start_i && !busy_o;
	assign k_ext = {{9{k_i[6]}}, k_i};
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	io_two_cycle_a:
		assert property (go && op_i inside {bfs_op_io_bit_set, bfs_op_io_bit_clear} |=> busy_o && !done_o ##1
			!busy_o && done_o && status_register_o == $past(status_register_o, 2)) else $error("io op timing");
	ovf_taken_a:
		assert property (go && op_i == bfs_op_branch_overflow_clear && !status_register_o[BFS_SB_V] |=> busy_o ##1
			done_o && pc_o == $past(pc_o, 2) + $past(k_ext, 2) + 16'h0001) else $error("overflow branch target");
	ovf_skip_a:
		assert property (go && op_i == bfs_op_branch_overflow_clear && status_register_o[BFS_SB_V] |=>
			!busy_o && done_o && pc_o == $past(pc_o) + 16'h0001) else $error("overflow branch not skipped");
	irq_en_taken_a:
		assert property (go && op_i == bfs_op_branch_irq_enabled && status_register_o[BFS_SB_I] |=> busy_o ##1
			pc_o == $past(pc_o, 2) + $past(k_ext, 2) + 16'h0001 && status_register_o == $past(status_register_o, 2))
			else $error("irq enabled branch");
	irq_dis_taken_a:
		assert property (go && op_i == bfs_op_branch_irq_disabled && !status_register_o[BFS_SB_I] |=> busy_o ##1
			pc_o == $past(pc_o, 2) + $past(k_ext, 2) + 16'h0001) else $error("irq disabled branch");
	shift_flags_a:
		assert property (go && op_i inside {[bfs_op_shift_left_logical:bfs_op_shift_right_arith]} |=> done_o &&
			status_register_o[3] == (status_register_o[2] ^ status_register_o[0]) &&
			((status_register_o ^ $past(status_register_o)) & 8'hf0) == 8'h00) else $error("shift flags");
	flags_kept_a:
		assert property (go && op_i inside {bfs_op_nibble_swap, bfs_op_load_bit_from_flag, bfs_op_register_copy}
			|=> done_o && $stable(status_register_o)) else $error("flags changed");
	sign_set_a:
		assert property (go && op_i == bfs_op_sign_flag_set |=> status_register_o == ($past(status_register_o) | 8'h10))
			else $error("sign set");
	bit_clear_a:
		assert property (go && op_i == bfs_op_status_bit_clear |=>
			status_register_o == ($past(status_register_o) & ~(8'h01 << $past(bit_sel_i)))) else $error("bit clear");
endmodule : bfs_datapath_chk

bind bfs_datapath bfs_datapath_chk i_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i),
	.bit_sel_i(bit_sel_i), .k_i(k_i), .pc_o(pc_o), .status_register_o(status_register_o), .busy_o(busy_o),
	.done_o(done_o));

//--- bfs_datapath_tb_top.sv
/*
 * bfs_datapath_tb_top: self-checking bench with a reference model.
 * Assumes the checker is bound to the datapath; inputs change at negedge.
 */
`timescale 1ns/1ns
module bfs_datapath_tb_top;
	import bfs_pkg::*;
	logic        mclk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        start_i = 1'b0;
	bfs_op_t     op_i = bfs_op_nop;
	logic [4:0]  rd_sel_i = 5'h00;
	logic [4:0]  rr_sel_i = 5'h00;
	logic [4:0]  io_sel_i = 5'h00;
	logic [4:0]  gpr_rd_addr_i = 5'h00;
	logic [4:0]  io_rd_addr_i = 5'h00;
	logic [2:0]  bit_sel_i = 3'h0;
	logic [6:0]  k_i = 7'h00;
	logic [15:0] pc_o;
	logic [7:0]  status_register_o;
	logic [7:0]  gpr_rd_data_o;
	logic [7:0]  io_rd_data_o;
	logic        busy_o;
	logic        done_o;
	int          bad_count = 0;
	int          comparisons = 0;
	logic [7:0]  gm [32];
	logic [7:0]  im [32];
	logic [7:0]  sm;
	logic [15:0] pm;
	localparam int unsigned FMAP [8] = '{BFS_SB_C, BFS_SB_N, BFS_SB_Z, BFS_SB_I, BFS_SB_S, BFS_SB_V, BFS_SB_T, BFS_SB_H};
	localparam bfs_op_t DL [16] = '{bfs_op_transfer_flag_set, bfs_op_load_bit_from_flag, bfs_op_shift_right_arith,
		bfs_op_carry_flag_set, bfs_op_rotate_right_carry, bfs_op_io_bit_set, bfs_op_io_bit_clear,
		bfs_op_overflow_flag_set, bfs_op_branch_overflow_clear, bfs_op_overflow_flag_clear,
		bfs_op_branch_overflow_clear, bfs_op_global_irq_on, bfs_op_branch_irq_enabled, bfs_op_branch_irq_disabled,
		bfs_op_global_irq_off, bfs_op_branch_irq_disabled};

	always #2 mclk_i = ~mclk_i;

	bfs_datapath i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i), .rd_sel_i(rd_sel_i),
		.rr_sel_i(rr_sel_i), .io_sel_i(io_sel_i), .bit_sel_i(bit_sel_i), .k_i(k_i), .gpr_rd_addr_i(gpr_rd_addr_i),
		.io_rd_addr_i(io_rd_addr_i), .pc_o(pc_o), .status_register_o(status_register_o),
		.gpr_rd_data_o(gpr_rd_data_o), .io_rd_data_o(io_rd_data_o), .busy_o(busy_o), .done_o(done_o));

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// returns {carry, result}
	function automatic logic [8:0] shf(input bfs_op_t op, input logic [7:0] v, input logic c);
		case (op)
			bfs_op_shift_left_logical:  return {v[7], v[6:0], 1'b0};
			bfs_op_shift_right_logical: return {v[0], 1'b0, v[7:1]};
			bfs_op_rotate_left_carry:   return {v[7], v[6:0], c};
			bfs_op_rotate_right_carry:  return {v[0], c, v[7:1]};
			default:                    return {v[0], v[7], v[7:1]};
		endcase
	endfunction : shf

	task automatic run(input bfs_op_t op, input logic [4:0] rd, input logic [4:0] rr, input logic [4:0] p,
		input logic [2:0] b, input logic [6:0] k);
		logic [8:0] r;
		logic [5:0] oc;
		logic       tk;
		logic [7:0] ge;
		logic [7:0] ie;
		logic [15:0] p1;
		oc = op;
		start_i = 1'b1;
		op_i = op;
		rd_sel_i = rd;
		rr_sel_i = rr;
		io_sel_i = p;
		bit_sel_i = b;
		k_i = k;
		gpr_rd_addr_i = $urandom_range(1, 0) ? rd : 5'($urandom);
		io_rd_addr_i = p;
		ge = gm[gpr_rd_addr_i];
		ie = im[p];
		tk = (op == bfs_op_branch_overflow_clear && !sm[BFS_SB_V]) || (op == bfs_op_branch_irq_enabled && sm[BFS_SB_I])
			|| (op == bfs_op_branch_irq_disabled && !sm[BFS_SB_I]);
		pm = pm + 16'h0001;
		p1 = pm;
		if (tk) begin
			pm = pm + {{9{k[6]}}, k};
		end
		case (op)
			bfs_op_io_bit_set:         im[p][b] = 1'b1;
			bfs_op_io_bit_clear:       im[p][b] = 1'b0;
			bfs_op_nibble_swap:        gm[rd] = {gm[rd][3:0], gm[rd][7:4]};
			bfs_op_status_bit_set:     sm[b] = 1'b1;
			bfs_op_status_bit_clear:   sm[b] = 1'b0;
			bfs_op_store_bit_to_flag:  sm[BFS_SB_T] = gm[rr][b];
			bfs_op_load_bit_from_flag: gm[rd][b] = sm[BFS_SB_T];
			bfs_op_register_copy:      gm[rd] = gm[rr];
			default: begin
				if (oc >= 6'd6 && oc <= 6'd10) begin
					r = shf(op, gm[rd], sm[BFS_SB_C]);
					gm[rd] = r[7:0];
					sm[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
				end
				if (oc >= 6'd16 && oc <= 6'd31) begin
					sm[FMAP[(oc - 6'd16) >> 1]] = ~oc[0];
				end
			end
		endcase
		@(posedge mclk_i);
		@(negedge mclk_i);
		check(busy_o, tk || op inside {bfs_op_io_bit_set, bfs_op_io_bit_clear});
		check(done_o, !(tk || op inside {bfs_op_io_bit_set, bfs_op_io_bit_clear}));
		check(pc_o, p1);
		if (busy_o === 1'b1) begin
			// a flag op offered while busy must be ignored
			start_i = 1'($urandom);
			op_i = bfs_op_t'(6'($urandom_range(31, 16)));
			@(posedge mclk_i);
			@(negedge mclk_i);
		end
		check(done_o, 1'b1);
		check(pc_o, pm);
		check(status_register_o, sm);
		check(gpr_rd_data_o, ge);
		check(io_rd_data_o, ie);
	endtask : run

	initial begin
		#20000;
		bad_count++;
		stop_test();
	end

	initial begin
		void'($urandom(45));
		for (int i = 0; i < 32; i++) begin
			gm[i] = BFS_BYTE_RST;
			im[i] = BFS_BYTE_RST;
		end
		sm = BFS_STATUS_REGISTER_RST;
		pm = BFS_PC_RST;
		repeat (16) @(posedge mclk_i);
		@(negedge mclk_i);
		check(pc_o, BFS_PC_RST);
		check(status_register_o, BFS_STATUS_REGISTER_RST);
		check({busy_o, done_o}, 16'h0000);
		check(gpr_rd_data_o, BFS_BYTE_RST);
		check(io_rd_data_o, BFS_BYTE_RST);
		rst_b_i = 1'b1;
		for (int i = 0; i < 16; i++) begin
			run(DL[i], 5'h01, 5'h01, 5'h1f, 3'h7, 7'h40);
		end
		// reset in mid-run with dirty state: all back to reset values
		start_i = 1'b0;
		rst_b_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		check(pc_o, BFS_PC_RST);
		check(status_register_o, BFS_STATUS_REGISTER_RST);
		check({busy_o, done_o}, 16'h0000);
		check(gpr_rd_data_o, BFS_BYTE_RST);
		check(io_rd_data_o, BFS_BYTE_RST);
		for (int i = 0; i < 32; i++) begin
			gm[i] = BFS_BYTE_RST;
			im[i] = BFS_BYTE_RST;
		end
		sm = BFS_STATUS_REGISTER_RST;
		pm = BFS_PC_RST;
		rst_b_i = 1'b1;
		for (int i = 0; i < 600; i++) begin
			run(bfs_op_t'(6'($urandom_range(32, 0))), 5'($urandom), 5'($urandom), 5'($urandom), 3'($urandom),
				7'($urandom));
		end
		start_i = 1'b0;
		stop_test();
	end
endmodule : bfs_datapath_tb_top
